/* File: design/cfg_status_class_defines.vh */
/*
 Constants for the configuration status and class code block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CFG_STATUS_CLASS_DEFINES_VH
`define CFG_STATUS_CLASS_DEFINES_VH

// ============================================================
// Register offsets (byte addresses in configuration space)
`define OFF_COMMAND 8'h04
`define OFF_STATUS 8'h06
`define OFF_CLASS 8'h08

// ============================================================
// Status bit positions
`define ST_POISON 15
`define ST_SYSERR 14
`define ST_UNSUP 13
`define ST_CA_REC 12
`define ST_CA_SIG 11
`define ST_DPAR 8
`define ST_CAPABILITY_LIST_PRESENT 4
`define ST_INTSTAT 3

// ============================================================
// Command bit positions
`define CMD_PERR 6
`define CMD_SERR 8

// ============================================================
// Reset values and class fields
`define STATUS_RESET 16'h0010
`define CMD_RESET 16'h0000
`define CLASS_BASE 8'h0c
`define CLASS_SUB 8'h03
`define CLASS_PGMIF 8'h30

`endif

/* File: design/sticky_flag.v */
/*
 One sticky event flag with write-one-to-clear.
 Assumes single clock, asynchronous active-high reset.
*/
`timescale 1ns/1ns
module sticky_flag (
    input wire clk,
    input wire sys_rst,
    input wire setEvent,
    input wire clearReq,
    output reg flag_q
);

// ============================================================
// Flag register
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        flag_q <= 1'b0;
    end else if (setEvent) begin
        flag_q <= 1'b1; // Set wins over clear
    end else if (clearReq) begin
        flag_q <= 1'b0;
    end
end

endmodule // sticky_flag

/* File: design/pcie_config_status_class.v */
/*
 Configuration status register and class code register of a USB host
 function, plus the command bits that gate the system error and data parity status flags.
 Assumes a simple synchronous configuration access port from the link
 core: one-cycle read/write strobes with byte address and byte enables.
*/
`timescale 1ns/1ns
`include "cfg_status_class_defines.vh"
module pcie_config_status_class #(
    parameter [7:0] SILICON_REV = 8'h01 // Arbitrary value
) (
    input wire clk,
    input wire sys_rst,
    input wire cfgRead,
    input wire cfgWrite,
    input wire [7:0] cfgAddr,
    input wire [3:0] cfgByteEn,
    input wire [31:0] cfgWrData,
    output reg [31:0] cfgRdData_q,
    output reg cfgRdValid_q,
    input wire rxPoisonedTlp,
    input wire txErrMessage,
    input wire rxCplUnsupported,
    input wire rxCplCompleterAbort,
    input wire txCplCompleterAbort,
    input wire rxCplPoisonedData,
    input wire rxWritePoisoned,
    input wire functionIntStatus,
    output wire parityResponseEnable,
    output wire systemErrorEnable
);

// ============================================================
// Address decode
wire [7:0] dwordAddr;
wire hitCommand;
wire hitClass;
wire cmdWrite;
wire statusClear;

assign dwordAddr = {cfgAddr[7:2], 2'b00};
assign hitCommand = (dwordAddr == `OFF_COMMAND);
assign hitClass = (dwordAddr == `OFF_CLASS);
assign cmdWrite = cfgWrite && hitCommand;
// Status sits in the upper half of the 04h dword
assign statusClear = cfgWrite && hitCommand;

// ============================================================
// Command bits
reg [15:0] command_q;

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        command_q <= `CMD_RESET;
    end else if (cmdWrite) begin
        if (cfgByteEn[0]) begin
            command_q[`CMD_PERR] <= cfgWrData[`CMD_PERR];
        end
        if (cfgByteEn[1]) begin
            command_q[`CMD_SERR] <= cfgWrData[`CMD_SERR];
        end
    end
end

assign parityResponseEnable = command_q[`CMD_PERR];
assign systemErrorEnable = command_q[`CMD_SERR];

// ============================================================
// Status event flags
wire [15:0] clrMask;
wire detected_poison_flag;
wire signaled_system_error;
wire received_unsupported_completion;
wire received_completer_abort;
wire signaled_completer_abort;
wire data_poison_error;
wire sysErrEvent;
wire dparEvent;

// Write one to clear, upper byte lanes of the dword
assign clrMask = statusClear ?
    ({{8{cfgByteEn[3]}}, {8{cfgByteEn[2]}}} & cfgWrData[31:16]) :
    16'h0000;
assign sysErrEvent = txErrMessage && systemErrorEnable;
assign dparEvent = (rxCplPoisonedData || rxWritePoisoned) &&
    parityResponseEnable;

sticky_flag poisonFlag (
    .clk(clk),
    .sys_rst(sys_rst),
    .setEvent(rxPoisonedTlp),
    .clearReq(clrMask[`ST_POISON]),
    .flag_q(detected_poison_flag)
);

sticky_flag sysErrFlag (
    .clk(clk),
    .sys_rst(sys_rst),
    .setEvent(sysErrEvent),
    .clearReq(clrMask[`ST_SYSERR]),
    .flag_q(signaled_system_error)
);

sticky_flag unsupFlag (
    .clk(clk),
    .sys_rst(sys_rst),
    .setEvent(rxCplUnsupported),
    .clearReq(clrMask[`ST_UNSUP]),
    .flag_q(received_unsupported_completion)
);

sticky_flag caRecFlag (
    .clk(clk),
    .sys_rst(sys_rst),
    .setEvent(rxCplCompleterAbort),
    .clearReq(clrMask[`ST_CA_REC]),
    .flag_q(received_completer_abort)
);

sticky_flag caSigFlag (
    .clk(clk),
    .sys_rst(sys_rst),
    .setEvent(txCplCompleterAbort),
    .clearReq(clrMask[`ST_CA_SIG]),
    .flag_q(signaled_completer_abort)
);

sticky_flag dparFlag (
    .clk(clk),
    .sys_rst(sys_rst),
    .setEvent(dparEvent),
    .clearReq(clrMask[`ST_DPAR]),
    .flag_q(data_poison_error)
);

// ============================================================
// Status and class assembly
reg [15:0] statusWord;
wire [31:0] classWord;

always @* begin
    statusWord = 16'h0000; // Reserved and hardwired bits
    statusWord[`ST_POISON] = detected_poison_flag;
    statusWord[`ST_SYSERR] = signaled_system_error;
    statusWord[`ST_UNSUP] = received_unsupported_completion;
    statusWord[`ST_CA_REC] = received_completer_abort;
    statusWord[`ST_CA_SIG] = signaled_completer_abort;
    statusWord[`ST_DPAR] = data_poison_error;
    statusWord[`ST_CAPABILITY_LIST_PRESENT] = 1'b1;
    statusWord[`ST_INTSTAT] = functionIntStatus;
end

// Constant only; no write path exists
assign classWord = {`CLASS_BASE, `CLASS_SUB, `CLASS_PGMIF,
    SILICON_REV};

// ============================================================
// Read port
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        cfgRdData_q <= 32'h00000000;
        cfgRdValid_q <= 1'b0;
    end else begin
        cfgRdValid_q <= cfgRead;
        if (cfgRead) begin
            if (hitCommand) begin
                cfgRdData_q <= {statusWord, command_q};
            end else if (hitClass) begin
                cfgRdData_q <= classWord;
            end else begin
                cfgRdData_q <= 32'h00000000;
            end
        end
    end
end

endmodule // pcie_config_status_class

/* File: verification/cfg_host_model.sv */
/*
 Configuration software side: dword reads, byte-enabled writes.
 Assumes tasks are entered just after a rising clock edge.
*/
`timescale 1ns/1ns
module cfg_host_model (
    input wire clk,
    input wire cfgRdValid_q,
    input wire [31:0] cfgRdData_q,
    output logic cfgRead = 1'b0,
    output logic cfgWrite = 1'b0,
    output logic [7:0] cfgAddr = 8'h00,
    output logic [3:0] cfgByteEn = 4'h0,
    output logic [31:0] cfgWrData = 32'h0
);
    // ====================
    // Access tasks
    task rd(input logic [7:0] a, output logic [31:0] d);
        cfgAddr = a;
        cfgRead = 1'b1;
        @(posedge clk);
        #1 cfgRead = 1'b0;
        d = cfgRdValid_q ? cfgRdData_q : 32'hx;
        @(posedge clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] be);
        cfgAddr = a;
        cfgWrData = v;
        cfgByteEn = be;
        cfgWrite = 1'b1;
        @(posedge clk);
        #1 cfgWrite = 1'b0;
        cfgWrData = ~v;
        @(posedge clk);
        #1;
    endtask
endmodule // cfg_host_model

/* File: verification/pcie_config_status_class_checker.sv */
/*
 Port checker for the status and class block.
 Assumes bind to the top module, one clock.
*/
`timescale 1ns/1ns
module pcie_config_status_class_checker (
    input wire clk,
    input wire sys_rst,
    input wire cfgRead,
    input wire [7:0] cfgAddr,
    input wire [31:0] cfgRdData_q,
    input wire rxPoisonedTlp,
    input wire txErrMessage,
    input wire rxCplCompleterAbort,
    input wire rxCplPoisonedData,
    input wire functionIntStatus,
    input wire parityResponseEnable,
    input wire systemErrorEnable
);
    // ====================
    // Read checks
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire rdSt = cfgRead & (cfgAddr[7:2] == 6'h01);
    wire rdCl = cfgRead & (cfgAddr[7:2] == 6'h02);
    property p_class; rdCl |=> cfgRdData_q[31:8] == 24'h0c0330; endproperty
    a_class: assert property (p_class) else $error("class");
    property p_rsvd; rdSt |=> (cfgRdData_q[31:16] & 16'h06e7) == 0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("rsvd");
    property p_cap; rdSt |=> cfgRdData_q[20]; endproperty
    a_cap: assert property (p_cap) else $error("cap");
    property p_int; rdSt |=> cfgRdData_q[19] == $past(functionIntStatus); endproperty
    a_int: assert property (p_int) else $error("int");
    property p_pois; rxPoisonedTlp ##1 rdSt |=> cfgRdData_q[31]; endproperty
    a_pois: assert property (p_pois) else $error("pois");
    property p_sys;
        txErrMessage && systemErrorEnable ##1 rdSt |=> cfgRdData_q[30];
    endproperty
    a_sys: assert property (p_sys) else $error("sys");
    property p_ca; rxCplCompleterAbort ##1 rdSt |=> cfgRdData_q[28]; endproperty
    a_ca: assert property (p_ca) else $error("ca");
    property p_dpar;
        rxCplPoisonedData && parityResponseEnable ##1 rdSt |=> cfgRdData_q[24];
    endproperty
    a_dpar: assert property (p_dpar) else $error("dpar");
    c_cl: cover property (rdCl);
    c_pois: cover property (rxPoisonedTlp ##1 rdSt);
    c_dpar: cover property (rxCplPoisonedData && parityResponseEnable);
endmodule // pcie_config_status_class_checker
bind pcie_config_status_class pcie_config_status_class_checker u_chk (.*);

/* File: verification/pcie_config_status_class_tb.sv */
/*
 Testbench for the status and class block.
 Assumes cfg_host_model for accesses and the bound checker.
*/
`timescale 1ns/1ns
module pcie_config_status_class_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic intStat = 1'b0;
    logic [6:0] ev = 7'h00;
    wire cfgRead, cfgWrite, cfgRdValid_q, perEn, serEn;
    wire [7:0] cfgAddr;
    wire [3:0] cfgByteEn;
    wire [31:0] cfgWrData, cfgRdData_q;
    int err_total = 0;
    int tests_run = 0;
    logic [31:0] d;
    logic [15:0] st, cmd;
    int pos [7] = '{15, 14, 13, 12, 11, 8, 8};
    bit gate [7] = '{0, 1, 0, 0, 0, 1, 1};
    // ====================
    // Clock and instances
    always #5 clk = ~clk;
    pcie_config_status_class #(.SILICON_REV(8'h5a)) u_pcie_config_status_class (
        .clk(clk), .sys_rst(sys_rst), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
        .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
        .cfgRdData_q(cfgRdData_q), .cfgRdValid_q(cfgRdValid_q),
        .rxPoisonedTlp(ev[0]), .txErrMessage(ev[1]), .rxCplUnsupported(ev[2]),
        .rxCplCompleterAbort(ev[3]), .txCplCompleterAbort(ev[4]),
        .rxCplPoisonedData(ev[5]), .rxWritePoisoned(ev[6]),
        .functionIntStatus(intStat), .parityResponseEnable(perEn),
        .systemErrorEnable(serEn));
    cfg_host_model u_cfg_host_model (.clk(clk), .cfgRdValid_q(cfgRdValid_q),
        .cfgRdData_q(cfgRdData_q), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
        .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData));
    // ====================
    // Tasks and sequence
    task chk(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s exp %h got %h", what, exp, got);
        end
    endtask
    task results;
        $display("Compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1 sys_rst = 1'b0;
        u_cfg_host_model.rd(8'h06, d);
        chk("reset", 32'h0010_0000, d);
        intStat = 1'b1;
        u_cfg_host_model.rd(8'h06, d);
        chk("intstat", 32'h0018_0000, d);
        u_cfg_host_model.wr(8'h08, 32'hffff_ffff, 4'hf);
        u_cfg_host_model.rd(8'h08, d);
        chk("class", 32'h0c03_305a, d);
        u_cfg_host_model.rd(8'h40, d);
        chk("unmapped", 32'h0, d);
        for (int e = 0; e < 2; e++) begin
            cmd = e ? 16'h0140 : 16'h0000;
            u_cfg_host_model.wr(8'h04, {16'h0, cmd}, 4'h3);
            chk("enables", {30'h0, e[0], e[0]}, {30'h0, perEn, serEn});
            for (int i = 0; i < 7; i++) begin
                ev[i] = 1'b1;
                @(posedge clk);
                #1 ev = 7'h00;
                st = 16'h0018;
                if (!gate[i] || e) st[pos[i]] = 1'b1;
                repeat (2) begin
                    u_cfg_host_model.rd(8'h06, d);
                    chk("set", {st, cmd}, d);
                end
                u_cfg_host_model.wr(8'h04, 32'hffff_0000, 4'hc);
                u_cfg_host_model.rd(8'h06, d);
                chk("clear", {16'h0018, cmd}, d);
            end
        end
        results;
    end
endmodule // pcie_config_status_class_tb
